// file: hw/asrx_pkg.sv
// asrx_pkg: shared constants for the asynchronous serial receiver
package asrx_pkg;
   localparam int ASRX_FIFO_DEPTH = 16;
   localparam int ASRX_DATA_W = 8;
   localparam int ASRX_OVS = 16;
   localparam logic [3:0] ASRX_MID_SAMPLE = 4'h7;
   localparam logic [3:0] ASRX_LAST_TICK = 4'hF;
   localparam logic [1:0] ASRX_PRE_DIV1 = 2'h0;
   localparam logic [1:0] ASRX_PRE_DIV4 = 2'h1;
   localparam logic [1:0] ASRX_PRE_DIV16 = 2'h2;
   localparam logic [1:0] ASRX_PRE_DIV64 = 2'h3;
   localparam logic [5:0] ASRX_PRE_MASK4 = 6'h03;
   localparam logic [5:0] ASRX_PRE_MASK16 = 6'h0F;
   localparam logic [5:0] ASRX_PRE_MASK64 = 6'h3F;
   localparam logic [4:0] ASRX_TRIG_RESET = 5'h08;
   localparam int ASRX_MAX_BPS_EXT = 781250;
   localparam logic [7:0] ASRX_BAUD_RESET = 8'h00;
   typedef enum logic [2:0] {
      ASRX_IDLE = 3'b000,
      ASRX_START = 3'b001,
      ASRX_DATA = 3'b010,
      ASRX_PARITY = 3'b011,
      ASRX_STOP = 3'b100
   } asrx_state_e;
endpackage : asrx_pkg

// file: hw/asrx_fifo.sv
// asrx_fifo: parameterised synchronous fifo with valid/ready on both sides
module asrx_fifo
   import asrx_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // fill level
   output logic [AW:0] count_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_q];
   assign count_o = cnt_q;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : asrx_fifo

// file: hw/asrx_receiver.sv
// asrx_receiver: asynchronous serial receiver with receive fifo and interrupt requests
// Functional notes
// - line rests high between characters; steady high is idle
// - a fall from idle to low starts a character as start bit
// - frame is start low, data bits, optional parity, high stop
// - each character is framed by its own start bit and stop bit
// - received characters are held in a 32-entry fifo and output register, at most sixteen at once
// - internal prescaler selects clock undivided, /4, /16 or /64
// - internal baud generator times receiver; clock at half the 16x tick rate can be driven out
// - external clock supports up to 781250 bits per second
// - data length is seven or eight bits
// - bit order selectable lsb first or msb first
// - framing, parity, overrun errors raise the receive error request
// - break on line raises a separate break request
// - receive error request is its own output line
// - threshold request when fill level reaches a nonzero trigger level
// - receive only when enabled; threshold and error requests gated by enable
// - parity disabled means no parity bit and no check
module asrx_receiver
   import asrx_pkg::*;
#(
   parameter int BUF_DEPTH = 32,
   parameter int HOLD_DEPTH = ASRX_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // serial line
   input wire logic rxd_i,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   // configuration
   input wire logic rx_enable_i,
   input wire logic rx_irq_enable_i,
   input wire logic parity_enable_i,
   input wire logic parity_odd_i,
   input wire logic char_length_select_i,
   input wire logic msb_first_i,
   input wire logic ext_clock_select_i,
   input wire logic clock_out_enable_i,
   input wire logic [1:0] prescale_select_i,
   input wire logic [7:0] baud_divisor_i,
   input wire logic [4:0] trigger_level_i,
   // status clear
   input wire logic error_clear_i,
   input wire logic break_clear_i,
   // received data
   output logic [ASRX_DATA_W-1:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [4:0] rx_count_o,
   // status and requests
   output logic framing_error_o,
   output logic parity_error_o,
   output logic overrun_error_o,
   output logic rx_fifo_threshold_irq_o,
   output logic rx_error_irq_o,
   output logic line_break_irq_o
);
   asrx_state_e state_q;
   logic [5:0] pre_q;
   logic pre_tick;
   logic [7:0] baud_q;
   logic int_tick;
   logic sck_q;
   logic ext_s0_q;
   logic ext_s1_q;
   logic ext_d_q;
   logic ext_tick;
   logic tick;
   logic [3:0] ph_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic par_q;
   logic [7:0] char_data;
   logic fe_q;
   logic pe_q;
   logic ore_q;
   logic brk_q;
   logic rxd_q;
   logic in_valid;
   logic in_ready;
   logic [7:0] in_data;
   logic [7:0] buf_data;
   logic buf_valid;
   logic [4:0] held_q;
   logic pop;
   logic char_done;
   logic mid;
   logic last_bit;

   // prescaler: divide by 1, 4, 16 or 64
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   always_comb begin
      case (prescale_select_i)
         ASRX_PRE_DIV4: pre_tick = (pre_q & ASRX_PRE_MASK4) == ASRX_PRE_MASK4;
         ASRX_PRE_DIV16: pre_tick = (pre_q & ASRX_PRE_MASK16) == ASRX_PRE_MASK16;
         ASRX_PRE_DIV64: pre_tick = (pre_q & ASRX_PRE_MASK64) == ASRX_PRE_MASK64;
         default: pre_tick = 1'b1;
      endcase
   end

   // baud generator produces the 16x sample tick
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         baud_q <= ASRX_BAUD_RESET;
         int_tick <= 1'b0;
         sck_q <= 1'b0;
      end else begin
         int_tick <= 1'b0;
         if (pre_tick) begin
            if (baud_q == '0) begin
               baud_q <= baud_divisor_i;
               int_tick <= 1'b1;
               sck_q <= ~sck_q;
            end else begin
               baud_q <= baud_q - 1'b1;
            end
         end
      end
   end

   // serial clock pin driven only with internal clock and output enabled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         serial_clock_pin_o <= 1'b0;
         serial_clock_pin_oe_o <= 1'b0;
      end else begin
         serial_clock_pin_o <= sck_q;
         serial_clock_pin_oe_o <= !ext_clock_select_i && clock_out_enable_i;
      end
   end

   // external 16x clock: rising edge becomes one tick
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ext_s0_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_d_q <= 1'b0;
      end else begin
         ext_s0_q <= serial_clock_pin_i;
         ext_s1_q <= ext_s0_q;
         ext_d_q <= ext_s1_q;
      end
   end

   assign ext_tick = ext_s1_q && !ext_d_q;
   assign tick = ext_clock_select_i ? ext_tick : int_tick;
   assign mid = tick && (ph_q == ASRX_MID_SAMPLE);
   assign last_bit = char_length_select_i ? (bit_q == 3'h6) : (bit_q == 3'h7);

   // line register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rxd_q <= 1'b1;
      end else begin
         rxd_q <= rxd_i;
      end
   end

   // receive state machine
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_q <= ASRX_IDLE;
         ph_q <= '0;
         bit_q <= '0;
         shift_q <= '0;
         par_q <= 1'b0;
      end else if (!rx_enable_i) begin
         state_q <= ASRX_IDLE;
         ph_q <= '0;
      end else begin
         if (tick) begin
            ph_q <= ph_q + 1'b1;
         end
         case (state_q)
            ASRX_IDLE: begin
               ph_q <= '0;
               bit_q <= '0;
               par_q <= parity_odd_i;
               if (!rxd_q) begin
                  state_q <= ASRX_START;
               end
            end
            ASRX_START: begin
               if (mid) begin
                  ph_q <= '0;
                  if (rxd_q) begin
                     state_q <= ASRX_IDLE;
                  end else begin
                     state_q <= ASRX_DATA;
                  end
               end
            end
            ASRX_DATA: begin
               if (tick && ph_q == ASRX_LAST_TICK) begin
                  shift_q[bit_q] <= rxd_q;
                  par_q <= par_q ^ rxd_q;
                  bit_q <= bit_q + 1'b1;
                  if (last_bit) begin
                     state_q <= parity_enable_i ? ASRX_PARITY : ASRX_STOP;
                  end
               end
            end
            ASRX_PARITY: begin
               if (tick && ph_q == ASRX_LAST_TICK) begin
                  par_q <= par_q ^ rxd_q;
                  state_q <= ASRX_STOP;
               end
            end
            ASRX_STOP: begin
               if (tick && ph_q == ASRX_LAST_TICK) begin
                  state_q <= ASRX_IDLE;
               end
            end
            default: state_q <= ASRX_IDLE;
         endcase
      end
   end

   assign char_done = rx_enable_i && (state_q == ASRX_STOP) && tick && (ph_q == ASRX_LAST_TICK);

   // bit order and length mapping
   always_comb begin
      char_data = shift_q;
      if (char_length_select_i) begin
         char_data[7] = 1'b0;
      end
      if (msb_first_i) begin
         for (int i = 0; i < 7; i++) begin
            char_data[i] = char_length_select_i ? shift_q[6-i] : shift_q[7-i];
         end
         char_data[7] = char_length_select_i ? 1'b0 : shift_q[0];
      end
   end

   assign in_data = char_data;
   assign in_valid = char_done && (held_q < 5'(HOLD_DEPTH)) && in_ready;

   // framing error: stop bit sampled low; set wins over clear
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         fe_q <= 1'b0;
      end else begin
         fe_q <= (fe_q && !error_clear_i) || (char_done && !rxd_q);
      end
   end

   // parity error: running parity sum not zero at the stop bit
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pe_q <= 1'b0;
      end else begin
         pe_q <= (pe_q && !error_clear_i) || (char_done && parity_enable_i && par_q);
      end
   end

   // overrun: character completes with no room left, character dropped
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ore_q <= 1'b0;
      end else begin
         ore_q <= (ore_q && !error_clear_i) || (char_done && !in_valid);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         brk_q <= 1'b0;
      end else begin
         brk_q <= (brk_q && !break_clear_i) || (char_done && !rxd_q && char_data == '0);
      end
   end

   asrx_fifo #(
      .WIDTH(ASRX_DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(in_valid),
      .in_ready_o(in_ready),
      .in_data_i(in_data),
      .out_valid_o(buf_valid),
      .out_ready_i(pop),
      .out_data_o(buf_data),
      .count_o()
   );

   assign pop = buf_valid && (!rx_valid_o || rx_ready_i);

   // held count: characters in buffer plus output register, capped at sixteen
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         held_q <= '0;
      end else begin
         held_q <= held_q + 5'(in_valid) - 5'(rx_valid_o && rx_ready_i);
      end
   end

   // output data register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_data_o <= '0;
         rx_valid_o <= 1'b0;
      end else if (pop) begin
         rx_data_o <= buf_data;
         rx_valid_o <= 1'b1;
      end else if (rx_ready_i) begin
         rx_valid_o <= 1'b0;
      end
   end

   // held count output
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_count_o <= '0;
      end else begin
         rx_count_o <= held_q;
      end
   end

   // sticky error status outputs
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         framing_error_o <= 1'b0;
         parity_error_o <= 1'b0;
         overrun_error_o <= 1'b0;
      end else begin
         framing_error_o <= fe_q;
         parity_error_o <= pe_q;
         overrun_error_o <= ore_q;
      end
   end

   // interrupt request outputs
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_fifo_threshold_irq_o <= 1'b0;
         rx_error_irq_o <= 1'b0;
         line_break_irq_o <= 1'b0;
      end else begin
         rx_fifo_threshold_irq_o <= rx_irq_enable_i && (held_q >= trigger_level_i)
            && (trigger_level_i != '0);
         rx_error_irq_o <= rx_irq_enable_i && (fe_q || pe_q || ore_q);
         line_break_irq_o <= brk_q;
      end
   end
endmodule : asrx_receiver

// file: verification/asrx_tx_model.sv
// asrx_tx_model: remote transmitter driving the serial line
module asrx_tx_model (
   // clock
   input wire logic clk_i,
   // serial line
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int bit_clks = 16;
   initial rxd_o = 1'b1;
   task automatic put(input logic v);
      rxd_o = v;
      repeat (bit_clks) @(posedge clk_i);
      #1;
   endtask : put
   task automatic send(input logic [7:0] d, input int n, input logic pen, input logic odd,
      input logic bad_par, input logic stop_v);
      logic p;
      p = odd ^ bad_par;
      put(1'b0);
      for (int i = 0; i < n; i++) begin
         put(d[i]);
         p = p ^ d[i];
      end
      if (pen) begin
         put(p);
      end
      put(stop_v);
      if (!stop_v) begin
         put(1'b1);
      end
   endtask : send
endmodule : asrx_tx_model

// file: verification/asrx_assertions.sv
// asrx_assertions: port checks bound to the serial receiver
module asrx_assertions
   import asrx_pkg::*;
#(
   parameter int HOLD_DEPTH = ASRX_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // controls
   input wire logic rx_irq_enable_i,
   input wire logic char_length_select_i,
   input wire logic [1:0] prescale_select_i,
   input wire logic [7:0] baud_divisor_i,
   input wire logic [4:0] trigger_level_i,
   input wire logic rx_ready_i,
   // outputs
   input wire logic [ASRX_DATA_W-1:0] rx_data_o,
   input wire logic rx_valid_o,
   input wire logic [4:0] rx_count_o,
   input wire logic framing_error_o,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe_o,
   input wire logic rx_fifo_threshold_irq_o,
   input wire logic rx_error_irq_o,
   input wire logic line_break_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_count_cap: assert property (rx_count_o <= 5'(HOLD_DEPTH))
      else $error("held count too high");
   a_data_hold: assert property (
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("data left before accept");
   a_seven_bit: assert property (
      $rose(rx_valid_o) && char_length_select_i |-> !rx_data_o[7])
      else $error("seven bit char has bit7 set");
   a_thr_gate: assert property (!rx_irq_enable_i [*2] |-> !rx_fifo_threshold_irq_o)
      else $error("threshold request while disabled");
   a_thr_level: assert property (
      (rx_irq_enable_i && trigger_level_i != 5'h00 && rx_count_o >= trigger_level_i) [*3]
      |-> rx_fifo_threshold_irq_o)
      else $error("threshold request missing");
   a_err_raise: assert property (
      $rose(framing_error_o) && rx_irq_enable_i |-> ##[0:2] rx_error_irq_o)
      else $error("error request missing");
   a_brk_cause: assert property ($rose(line_break_irq_o) |-> ##[0:2] framing_error_o)
      else $error("break without framing error");
   a_clk_toggle: assert property (
      (serial_clock_pin_oe_o && baud_divisor_i == 8'h00 && prescale_select_i == ASRX_PRE_DIV1)
      [*3] |-> serial_clock_pin_o != $past(serial_clock_pin_o))
      else $error("clock out not toggling");
   c_full: cover property (rx_count_o == 5'(HOLD_DEPTH));
   c_brk: cover property ($rose(line_break_irq_o));
   c_thr: cover property ($rose(rx_fifo_threshold_irq_o));
endmodule : asrx_assertions
bind asrx_receiver asrx_assertions #(.HOLD_DEPTH(HOLD_DEPTH)) u_asrx_assertions (
   .clk_i, .reset_n_i, .rx_irq_enable_i, .char_length_select_i, .prescale_select_i,
   .baud_divisor_i, .trigger_level_i, .rx_ready_i, .rx_data_o, .rx_valid_o, .rx_count_o,
   .framing_error_o, .serial_clock_pin_o, .serial_clock_pin_oe_o, .rx_fifo_threshold_irq_o,
   .rx_error_irq_o, .line_break_irq_o);

// file: verification/testbench.sv
// testbench: self-checking bench for the serial receiver
module testbench
   import asrx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0, reset_n_i = 1'b0, sck = 1'b0, en = 1'b1, ie = 1'b0, pen = 1'b0;
   logic odd = 1'b0, clen = 1'b0, msb = 1'b0, ext = 1'b0, eclr = 1'b0, bclr = 1'b0, rdy = 1'b1;
   logic coe = 1'b1;
   logic [1:0] pre = 2'h0;
   logic [7:0] div = 8'h00;
   logic [4:0] trig = 5'h08;
   logic rxd, rv, fe, perr, ov, thr, rx_error_irq, line_break_irq, sco, scoe;
   logic [7:0] rd;
   logic [4:0] cnt;
   logic [7:0] q[$];
   logic [31:0] seed = 32'h5E74;
   int failures = 0, comparisons = 0;
   asrx_tx_model line (.clk_i(clk_i), .rxd_o(rxd));
   asrx_receiver dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rxd_i(rxd),
      .serial_clock_pin_i(sck), .serial_clock_pin_o(sco), .serial_clock_pin_oe_o(scoe),
      .rx_enable_i(en), .rx_irq_enable_i(ie), .parity_enable_i(pen), .parity_odd_i(odd),
      .char_length_select_i(clen), .msb_first_i(msb), .ext_clock_select_i(ext),
      .clock_out_enable_i(coe), .prescale_select_i(pre), .baud_divisor_i(div),
      .trigger_level_i(trig), .error_clear_i(eclr), .break_clear_i(bclr), .rx_data_o(rd),
      .rx_valid_o(rv), .rx_ready_i(rdy), .rx_count_o(cnt), .framing_error_o(fe),
      .parity_error_o(perr), .overrun_error_o(ov), .rx_fifo_threshold_irq_o(thr),
      .rx_error_irq_o(rx_error_irq), .line_break_irq_o(line_break_irq));
   always #25 clk_i = ~clk_i;
   always begin
      repeat (2) @(posedge clk_i);
      #1;
      sck = ~sck;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] want(input logic [7:0] d, input int n);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         r[msb ? n - 1 - i : i] = d[i];
      end
      return r;
   endfunction : want
   task automatic cmp_val(input string n, input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_val
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   always @(posedge clk_i) begin
      if (rv === 1'b1 && rdy === 1'b1) begin
         cmp_val("char", q.size() > 0 ? {1'b0, q.pop_front()} : 9'h100, {1'b0, rd});
      end
   end
   task automatic tx(input logic [7:0] d, input logic bp, input logic sv, input logic keep);
      if (keep) begin
         q.push_back(want(d, clen ? 7 : 8));
      end
      line.send(d, clen ? 7 : 8, pen, odd, bp, sv);
   endtask : tx
   task automatic rnd(input logic keep);
      seed = lfsr(seed);
      tx(seed[7:0], 1'b0, 1'b1, keep);
   endtask : rnd
   task automatic edges(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : edges
   task automatic rst();
      reset_n_i = 1'b0;
      edges(16);
      reset_n_i = 1'b1;
      edges(2);
   endtask : rst
   task automatic drain();
      for (int i = 0; i < 3000 && q.size() > 0; i++) begin
         @(posedge clk_i);
      end
      #1;
      if (q.size() > 0) begin
         failures++;
         test_done();
      end
   endtask : drain
   task automatic flags(input logic [3:0] e);
      edges(4);
      cmp_val("flags", {5'h00, e}, {5'h00, fe, perr, line_break_irq, rx_error_irq});
   endtask : flags
   task automatic clr();
      eclr = 1'b1;
      bclr = 1'b1;
      edges(2);
      eclr = 1'b0;
      bclr = 1'b0;
   endtask : clr
   initial begin
      rst();
      for (int m = 0; m < 8; m++) begin
         {pen, msb, clen} = m[2:0];
         odd = seed[3];
         repeat (3) rnd(1'b1);
         drain();
      end
      {pen, msb, clen} = 3'h0;
      rdy = 1'b0;
      ie = 1'b1;
      for (int k = 0; k <= ASRX_FIFO_DEPTH; k++) begin
         rnd(k < ASRX_FIFO_DEPTH);
         edges(4);
         cmp_val("count", 9'(k < ASRX_FIFO_DEPTH ? k + 1 : k), {4'h0, cnt});
         cmp_val("thr", {8'h00, k >= 7}, {8'h00, thr});
      end
      cmp_val("ovr", 9'h003, {7'h00, ov, rx_error_irq});
      trig = 5'h00;
      edges(3);
      cmp_val("thr_off", 9'h000, {8'h00, thr});
      trig = 5'h08;
      ie = 1'b0;
      edges(3);
      cmp_val("irqs", 9'h000, {7'h00, thr, rx_error_irq});
      rdy = 1'b1;
      drain();
      edges(2);
      cmp_val("count", 9'h000, {4'h0, cnt});
      rst();
      rdy = 1'b0;
      ie = 1'b1;
      pen = 1'b1;
      odd = 1'b1;
      tx(8'h5A, 1'b1, 1'b1, 1'b0);
      flags(4'h5);
      clr();
      flags(4'h0);
      pen = 1'b0;
      tx(8'hA5, 1'b0, 1'b0, 1'b0);
      flags(4'h9);
      clr();
      tx(8'h00, 1'b0, 1'b0, 1'b0);
      flags(4'hB);
      clr();
      flags(4'h0);
      rst();
      rdy = 1'b1;
      en = 1'b0;
      rnd(1'b0);
      edges(4);
      cmp_val("count", 9'h000, {4'h0, cnt});
      en = 1'b1;
      div = 8'h01;
      for (int p = 0; p < 4; p++) begin
         pre = p[1:0];
         line.bit_clks = 32 << (2 * p);
         rnd(1'b1);
         drain();
      end
      cmp_val("clk_oe", 9'h001, {8'h00, scoe});
      coe = 1'b0;
      edges(2);
      cmp_val("clk_oe", 9'h000, {8'h00, scoe});
      coe = 1'b1;
      ext = 1'b1;
      line.bit_clks = 64;
      rnd(1'b1);
      drain();
      cmp_val("clk_oe", 9'h000, {8'h00, scoe});
      test_done();
   end
endmodule : testbench
